/* File: hw/see_command_port.sv */
// Purpose: Serial command front end of a 16-kilobit erasable memory.
// Assumes: Link pins are asynchronous and sampled by the 25 MHz clock.
// Notes:   Shift clock edges are found by sampling; it must run slower than clock / 4.
//
// Summary of operation
// - The array is 1024 sixteen-bit words with the strap high and 2048 bytes with it low.
// - A floating strap reads high through the pad pull-up, giving sixteen-bit words.
// - The host selects with chip select and talks over serial in, serial out and shift clock.
// - A read command decodes its address and shifts the stored word out on serial out.
// - Each write cycle runs on internal timing without shift clocks and ends within 10 ms.
// - A write overwrites a location directly with no erase needed first.
// - Programming commands are ignored unless programming has been enabled.
// - After a write cycle starts, raising chip select shows ready/busy on serial out.
// - Opcodes are read 10, write 01, erase 11, and 00 with address top bits 11/10/01/00.
// - Read data change on rising shift clock edges after one leading zero dummy bit.
// - With chip select held high a read continues through following words without dummy bits.
`default_nettype none
module see_command_port #(
  parameter int WRITE_CYCLES = see_pkg::WRITE_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic chipSelect,
  input  wire logic shiftClockIn,
  input  wire logic serialIn,
  input  wire logic organizationSelect,
  output logic      serialOut,
  output logic      serialOutEnN
);
  import see_pkg::*;

  localparam int TW = $clog2(WRITE_CYCLES + 1);

  // Two-stage synchronisers for every pin; only the second stage is read by logic.
  logic [1:0] csSync, skSync, diSync, orgSync;
  logic       skPrev;
  always_ff @(posedge clock) begin
    csSync  <= {csSync[0], chipSelect};
    skSync  <= {skSync[0], shiftClockIn};
    diSync  <= {diSync[0], serialIn};
    orgSync <= {orgSync[0], organizationSelect};
    skPrev  <= skSync[1];
  end

  wire logic csLevel = csSync[1];
  wire logic diBit   = diSync[1];
  wire logic skRise  = skSync[1] & ~skPrev;
  // The pad pull-up turns an open strap into a high level here.
  wire logic wide16  = orgSync[1];

  see_state_t  state;
  logic        progEn, armed, statusShow, sweeping, doBit;
  logic [4:0]  cnt;
  logic [12:0] sh;
  logic [15:0] rdSh;
  logic [10:0] ptr;
  logic [9:0]  sweepIdx;
  logic [TW-1:0] timer;
  see_job_t    job;
  logic [15:0] rdata;
  see_mem_req_t memReq;

  // Command field extraction from the bits collected so far.
  wire logic [12:0] shNext  = {sh[11:0], diBit};
  wire logic [4:0]  cmdBits = wide16 ? 5'(OPC_W + ADDR_W16) : 5'(OPC_W + ADDR_W8);
  wire logic        cmdLast = (cnt == cmdBits - 5'd1);
  wire logic [1:0]  opcNow  = wide16 ? shNext[11:10] : shNext[12:11];
  wire logic [1:0]  extNow  = wide16 ? shNext[9:8]   : shNext[10:9];
  wire logic [10:0] addrNow = wide16 ? {1'b0, shNext[9:0]} : shNext[10:0];
  wire logic [4:0]  dataLast = wide16 ? 5'(DATA_W16 - 1) : 5'(DATA_W8 - 1);

  // Read side: word address, selected byte, and the next pointer value.
  wire logic [9:0]  rdWord  = wide16 ? ptr[9:0] : ptr[10:1];
  wire logic [15:0] curWord = wide16 ? rdata
                                     : {(ptr[0] ? rdata[7:0] : rdata[15:8]), 8'h00};
  wire logic [10:0] ptrInc  = wide16 ? {1'b0, ptr[9:0] + 10'h001} : ptr + 11'h001;
  wire logic [3:0]  wordTop = wide16 ? 4'(DATA_W16 - 1) : 4'(DATA_W8 - 1);
  logic [3:0] bitLeft;

  // Write side: data, lanes and word of the pending job.
  wire logic [15:0] jobData = job.erase ? ERASED_WORD
                            : (wide16 ? job.data : {job.data[7:0], job.data[7:0]});
  wire logic [1:0]  jobBe   = (wide16 || job.all) ? 2'b11
                            : (job.addr[0] ? 2'b01 : 2'b10);
  wire logic [9:0]  jobWord = wide16 ? job.addr[9:0] : job.addr[10:1];
  wire logic        sweepLast = !job.all || (sweepIdx == LAST_WORD);
  wire logic        timerDone = (timer == TW'(WRITE_CYCLES - 1));

  // The array sees writes while sweeping, otherwise the read pointer.
  assign memReq = '{addr: (sweeping ? sweepIdx : rdWord),
                    we:   (sweeping ? jobBe : 2'b00),
                    data: jobData};

  see_mem uMem (
    .clock (clock),
    .req   (memReq),
    .rdata (rdata)
  );

  // Command decode, read streaming and the self-timed write sequencer.
  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= ST_IDLE;
      progEn     <= PROG_EN_RESET;
      armed      <= 1'b0;
      statusShow <= 1'b0;
      sweeping   <= 1'b0;
      doBit      <= 1'b0;
      cnt        <= '0;
      sh         <= '0;
      rdSh       <= '0;
      ptr        <= '0;
      bitLeft    <= '0;
      sweepIdx   <= '0;
      timer      <= '0;
      job        <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (!csLevel) begin
            statusShow <= 1'b0;
          end else if (skRise && diBit) begin
            state      <= ST_CMD;
            statusShow <= 1'b0;
            cnt        <= '0;
            sh         <= '0;
          end
        end
        ST_CMD: begin
          if (!csLevel) begin
            state <= ST_IDLE;
          end else if (skRise) begin
            sh  <= shNext;
            cnt <= cnt + 5'd1;
            if (cmdLast) begin
              job <= '{all: 1'b0, erase: 1'b0, addr: addrNow, data: 16'h0000};
              state <= ST_HOLD;
              case (opcNow)
                OPC_READ: begin
                  state   <= ST_READ;
                  ptr     <= addrNow;
                  doBit   <= 1'b0;
                  bitLeft <= '0;
                end
                OPC_WRITE: begin
                  cnt <= '0;
                  if (progEn) state <= ST_DATA;
                end
                OPC_ERASE: begin
                  job.erase <= 1'b1;
                  armed     <= progEn;
                end
                default: begin
                  case (extNow)
                    EXT_ENABLE:  progEn <= 1'b1;
                    EXT_DISABLE: progEn <= 1'b0;
                    EXT_ERASE_ALL: begin
                      job.all   <= 1'b1;
                      job.erase <= 1'b1;
                      armed     <= progEn;
                    end
                    default: begin
                      job.all <= 1'b1;
                      cnt     <= '0;
                      if (progEn) state <= ST_DATA;
                    end
                  endcase
                end
              endcase
            end
          end
        end
        ST_DATA: begin
          if (!csLevel) begin
            state <= ST_IDLE;                   // Short data aborts the command.
          end else if (skRise) begin
            job.data <= {job.data[14:0], diBit};
            cnt      <= cnt + 5'd1;
            if (cnt == dataLast) begin
              armed <= 1'b1;
              state <= ST_HOLD;
            end
          end
        end
        ST_READ: begin
          if (!csLevel) begin
            state <= ST_IDLE;
          end else if (skRise) begin
            if (bitLeft == 4'h0) begin
              doBit   <= curWord[15];
              rdSh    <= {curWord[14:0], 1'b0};
              bitLeft <= wordTop;
              ptr     <= ptrInc;
            end else begin
              doBit   <= rdSh[15];
              rdSh    <= {rdSh[14:0], 1'b0};
              bitLeft <= bitLeft - 4'h1;
            end
          end
        end
        ST_HOLD: begin
          // The write cycle starts when chip select falls after a complete job.
          if (!csLevel) begin
            state <= armed ? ST_BUSY : ST_IDLE;
            sweeping <= armed;
            sweepIdx <= job.all ? 10'h000 : jobWord;
            timer    <= '0;
            armed    <= 1'b0;
          end
        end
        default: begin
          // Self-timed: counts clocks only, shift clock edges are ignored.
          timer <= timer + TW'(1);
          if (sweeping) begin
            sweepIdx <= sweepIdx + 10'h001;
            if (sweepLast) sweeping <= 1'b0;
          end
          if (timerDone) begin
            state      <= ST_IDLE;
            statusShow <= 1'b1;
          end
        end
      endcase
    end
  end

  // Serial out is driven only while selected in a read or a status phase.
  wire logic driveNow = csLevel && (state == ST_READ || state == ST_BUSY || statusShow);
  wire logic outLevel = (state == ST_BUSY) ? 1'b0 : (statusShow ? 1'b1 : doBit);
  always_ff @(posedge clock) begin
    if (rst) begin
      serialOut    <= 1'b0;
      serialOutEnN <= 1'b1;
    end else begin
      serialOut    <= outLevel;
      serialOutEnN <= ~driveNow;
    end
  end
endmodule
`default_nettype wire

/* File: pkg/see_pkg.sv */
// Purpose: Shared constants and types for the serial memory command port.
// Assumes: One 25 MHz system clock; all link pins are asynchronous to it.
// Notes:   Opcodes and field widths are fixed by the serial protocol.
`default_nettype none
package see_pkg;
  // System clock rate and the self-timed write cycle budget.
  localparam int CLK_HZ        = 25_000_000;
  localparam int WRITE_TIME_US = 10_000;
  // Longest time rounds down to whole cycles.
  localparam int WRITE_CYCLES  = (CLK_HZ / 1_000_000) * WRITE_TIME_US;

  // Array shape: 1024 words of 16 bits, or 2048 bytes.
  localparam int WORDS     = 1024;
  localparam int ADDR_W16  = 10;
  localparam int ADDR_W8   = 11;
  localparam int DATA_W16  = 16;
  localparam int DATA_W8   = 8;
  localparam int OPC_W     = 2;
  localparam logic [9:0] LAST_WORD = 10'h3ff;

  // Operation codes following the start bit.
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] OPC_EXT   = 2'h0;
  // Extended commands carried in the two top address bits.
  localparam logic [1:0] EXT_ENABLE    = 2'h3;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_FILL_ALL  = 2'h1;
  localparam logic [1:0] EXT_DISABLE   = 2'h0;

  // Enable reset value and the word an erase writes.
  localparam logic        PROG_EN_RESET = 1'b0;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_DATA, ST_READ, ST_HOLD, ST_BUSY
  } see_state_t;

  // A programming job waiting for chip select to fall.
  typedef struct packed {
    logic        all;
    logic        erase;
    logic [10:0] addr;
    logic [15:0] data;
  } see_job_t;

  // One access to the storage array; lane 1 holds the even byte.
  typedef struct packed {
    logic [9:0]  addr;
    logic [1:0]  we;
    logic [15:0] data;
  } see_mem_req_t;
endpackage
`default_nettype wire

/* File: hw/see_mem.sv */
// Purpose: 1024 x 16 storage array with two independently written byte lanes.
// Assumes: Single clock; read data are registered, one cycle after the address.
// Notes:   Each lane is its own array so that no array has two writers.
`default_nettype none
module see_mem (
  input  wire logic                  clock,
  input  wire see_pkg::see_mem_req_t req,
  output logic [15:0]                rdata
);
  import see_pkg::*;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gLane
      logic [7:0] lane [WORDS];
      logic [7:0] q;
      // A write lands on the lane whose enable is set; read is always performed.
      always_ff @(posedge clock) begin
        if (req.we[g]) begin
          lane[req.addr] <= req.data[8*g +: 8];
        end
        q <= lane[req.addr];
      end
      // Each lane owns its own read register, so no output bit has two writers.
      assign rdata[8*g +: 8] = q;
    end
  endgenerate
endmodule
`default_nettype wire

/* File: test/see_command_port_props.sv */
// Purpose: Port-level assertions for the serial memory command port.
// Assumes: Link pins are seen raw; the design answers about four clocks after an edge.
// Notes:   A small shadow of the command header tells reads apart from other traffic.
`default_nettype none
module see_command_port_props #(
  parameter int WRITE_CYCLES = see_pkg::WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic chipSelect,
  input wire logic shiftClockIn,
  input wire logic serialIn,
  input wire logic organizationSelect,
  input wire logic serialOut,
  input wire logic serialOutEnN
);
  logic       sckPrev;
  logic [2:0] hdr;
  int         cnt;
  int         sinceRise;
  int         lowCnt;
  // Header decode; a byte array needs one address bit more before data start.
  wire sckRise  = shiftClockIn && !sckPrev;
  wire readCmd  = (cnt >= 3) && (hdr == 3'b110);
  wire [4:0] lastA = organizationSelect ? 5'd13 : 5'd14;
  wire readEdge = readCmd && sckRise && (cnt == int'(lastA) - 1);
  wire readOn   = readCmd && (cnt >= int'(lastA));
  // Edge counter and busy-time counter; both restart whenever select drops.
  always_ff @(posedge clock) begin
    sckPrev <= shiftClockIn;
    sinceRise <= sckRise ? 0 : (sinceRise < 15 ? sinceRise + 1 : sinceRise);
    lowCnt <= (chipSelect && cnt == 0 && !serialOutEnN && !serialOut) ? lowCnt + 1 : 0;
    if (rst || !chipSelect) begin
      cnt <= 0;
      hdr <= 3'h0;
    end else if (sckRise) begin
      cnt <= cnt + 1;
      if (cnt < 3) hdr <= {hdr[1:0], serialIn};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_release: assert property (disable iff (1'b0) rst |=> serialOutEnN && !serialOut)
    else $error("outputs not idle after reset");
  a_idle_released: assert property (!chipSelect [*8] |-> serialOutEnN)
    else $error("serial out driven while deselected");
  a_read_drives: assert property (readEdge |-> ##6 !serialOutEnN)
    else $error("read answer not driven");
  a_dummy_zero: assert property (readEdge |-> ##6 !serialOut)
    else $error("leading dummy bit is not zero");
  a_byte_addr_len: assert property (readCmd && sckRise && !organizationSelect && cnt == 12
    |-> ##6 serialOutEnN)
    else $error("byte read answered one address bit early");
  a_read_stable: assert property (readOn && chipSelect && sinceRise >= 6 |-> $stable(serialOut))
    else $error("read data moved without a rising shift edge");
  a_busy_bounded: assert property (lowCnt <= WRITE_CYCLES + 16)
    else $error("write cycle outlasts its budget");
  a_ready_holds: assert property (chipSelect && cnt == 0 && !serialOutEnN && serialOut
    && !sckRise |=> serialOut || serialOutEnN)
    else $error("ready status fell back");
  c_read: cover property (readEdge);
  c_byte_read: cover property (readEdge && !organizationSelect);
  c_busy: cover property (lowCnt == 10);
endmodule
bind see_command_port see_command_port_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_props (
  .clock(clock), .rst(rst), .chipSelect(chipSelect), .shiftClockIn(shiftClockIn),
  .serialIn(serialIn), .organizationSelect(organizationSelect), .serialOut(serialOut),
  .serialOutEnN(serialOutEnN));
`default_nettype wire

/* File: test/see_host_model.sv */
// Purpose: Host side of the three-wire link, driving select, shift clock and data.
// Assumes: Shift clock period is nine system clocks; it stands low between frames.
// Notes:   A released output line reads as the inverse of the serial out register.
`default_nettype none
module see_host_model (
  input  wire logic clock,
  input  wire logic serialOut,
  input  wire logic serialOutEnN,
  output logic      chipSelect,
  output logic      shiftClockIn,
  output logic      serialIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Nothing pulls the line, so a released pin must not look like valid data.
  wire doLine = serialOutEnN ? ~serialOut : serialOut;
  initial begin
    chipSelect = 1'b0;
    shiftClockIn = 1'b0;
    serialIn = 1'b0;
  end
  // Select or deselect, then wait long enough to meet the select low time.
  task automatic select(input logic on);
    @(posedge clock);
    chipSelect <= on;
    repeat (8) @(posedge clock);
  endtask
  // Each bit: data set up in the low phase, line sampled just before the rise.
  task automatic bits(input int n, input logic [39:0] v, output logic [39:0] got);
    got = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clock);
      serialIn <= v[i];
      repeat (4) @(posedge clock);
      got = {got[38:0], doLine};
      shiftClockIn <= 1'b1;
      repeat (4) @(posedge clock);
      shiftClockIn <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the serial memory command port.
// Assumes: A short write budget keeps each self-timed cycle brief.
// Notes:   Memory starts unknown, so the first scenario erases everything.
`default_nettype none
module testbench;
  import see_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 2000;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        organization_select = 1'b1; // Level of a floating strap held by its pull-up.
  wire logic   cs;
  wire logic   sck;
  wire logic   sdi;
  wire logic   sdo;
  wire logic   sdoEnN;
  logic [39:0] g;
  int          n_fail = 0;
  int          check_count = 0;
  always #20 clock = ~clock;
  see_command_port #(.WRITE_CYCLES(WC)) i_dut (.clock(clock), .rst(rst), .chipSelect(cs),
    .shiftClockIn(sck), .serialIn(sdi), .organizationSelect(organization_select), .serialOut(sdo),
    .serialOutEnN(sdoEnN));
  see_host_model i_host (.clock(clock), .serialOut(sdo), .serialOutEnN(sdoEnN),
    .chipSelect(cs), .shiftClockIn(sck), .serialIn(sdi));
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  // Start bit, opcode and address sized by the strap, then any data.
  task automatic cmd(input logic [1:0] opc, input logic [10:0] adr, input int nd,
    input logic [15:0] d);
    logic [39:0] x;
    i_host.select(1'b1);
    i_host.bits(3, {37'h0, 1'b1, opc}, x);
    i_host.bits(organization_select ? 10 : 11, {29'h0, adr}, x);
    if (nd > 0) i_host.bits(nd, {24'h0, d}, x);
  endtask
  task automatic ext(input logic [1:0] e);
    cmd(OPC_EXT, {1'b0, e, 8'h00}, 0, 16'h0);
    i_host.select(1'b0);
  endtask
  // Programming job: busy low on reselect, then ready within the budget.
  task automatic prog(input logic [1:0] opc, input logic [10:0] adr, input int nd,
    input logic [15:0] d);
    int n;
    cmd(opc, adr, nd, d);
    i_host.select(1'b0);
    i_host.select(1'b1);
    chk("busy status", 40'h0, {38'h0, sdoEnN, i_host.doLine});
    n = 0;
    // A released line must not pass for ready, so the enable is watched too.
    while ({sdoEnN, i_host.doLine} !== 2'b01 && n < WC + 100) begin
      @(posedge clock);
      n++;
    end
    chk("ready status", 40'h1, {38'h0, sdoEnN, i_host.doLine});
    i_host.select(1'b0);
  endtask
  task automatic rd(input logic [10:0] adr, input int n, output logic [39:0] got);
    cmd(OPC_READ, adr, 0, 16'h0);
    i_host.bits(n + 1, 40'h0, got);
    i_host.select(1'b0);
  endtask
  task automatic t_guard;
    ext(EXT_ENABLE);
    prog(OPC_EXT, {1'b0, EXT_ERASE_ALL, 8'h00}, 0, 16'h0);
    ext(EXT_DISABLE);
    cmd(OPC_WRITE, 11'h005, 16, 16'h1234);
    i_host.select(1'b0);
    rd(11'h005, 16, g);
    chk("guarded word", {24'h0, ERASED_WORD}, g);
  endtask
  task automatic t_words;
    ext(EXT_ENABLE);
    prog(OPC_WRITE, 11'h005, 16, 16'ha5c3);
    prog(OPC_WRITE, 11'h005, 16, 16'h3c5a);
    prog(OPC_WRITE, 11'h006, 16, 16'h0f0f);
    rd(11'h005, 32, g);
    chk("sequential words", {7'h0, 1'b0, 16'h3c5a, 16'h0f0f}, g);
  endtask
  task automatic t_bytes;
    @(posedge clock) organization_select <= 1'b0;
    prog(OPC_WRITE, 11'h00b, 8, 16'h007e);
    rd(11'h00a, 16, g);
    chk("byte pair", {23'h0, 1'b0, 8'h3c, 8'h7e}, g);
    @(posedge clock) organization_select <= 1'b1;
    rd(11'h005, 16, g);
    chk("word view", {23'h0, 1'b0, 16'h3c7e}, g);
  endtask
  task automatic t_bulk;
    prog(OPC_EXT, {1'b0, EXT_FILL_ALL, 8'h00}, 16, 16'h1111);
    prog(OPC_ERASE, 11'h006, 0, 16'h0);
    rd(11'h005, 32, g);
    chk("erased word", {8'h0, 16'h1111, 16'hffff}, g);
    rd({1'b0, LAST_WORD}, 32, g);
    chk("wrapped read", {8'h0, 16'h1111, 16'h1111}, g);
    ext(EXT_DISABLE);
    cmd(OPC_ERASE, 11'h005, 0, 16'h0);
    i_host.select(1'b0);
    rd(11'h005, 16, g);
    chk("disabled erase", {24'h0, 16'h1111}, g);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // The scenarios take about 0.8 ms; three times that means a hang.
  initial begin
    #2_400_000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_guard();
    t_words();
    t_bytes();
    t_bulk();
    report_and_stop();
  end
endmodule
`default_nettype wire
